// [design/rtcu_pkg.sv]
// Constants for the calendar-clock control block: offsets, fields, timing.
// Assumes a Wishbone classic slave with 32-bit data, one register per word.
package rtcu_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_YEAR = 4'h9;
   localparam logic [3:0] IDX_DIVRATE = 4'hA;
   localparam logic [3:0] IDX_UPDFMT = 4'hB;
   localparam logic [3:0] IDX_STATUS = 4'hC;
   // Divider-rate control fields
   localparam int DRC_PEND_BIT = 7;
   localparam int DRC_CHAIN_LSB = 4;
   localparam logic [2:0] CHAIN_RUN = 3'h2;
   localparam logic [1:0] CHAIN_HALT_TOP = 2'h3;
   // Update-format control fields
   localparam int UFC_INHIBIT_BIT = 7;
   localparam int UFC_PER_EN_BIT = 6;
   localparam int UFC_ALM_EN_BIT = 5;
   localparam int UFC_UPD_EN_BIT = 4;
   localparam int UFC_RSVD_BIT = 3;
   localparam int UFC_FMT_BIT = 2;
   localparam int UFC_H24_BIT = 1;
   localparam int UFC_DST_BIT = 0;
   // Status fields
   localparam int ST_REQ_BIT = 7;
   localparam int ST_PER_BIT = 6;
   localparam int ST_ALM_BIT = 5;
   localparam int ST_UEND_BIT = 4;
   // Reset values
   localparam logic [7:0] YEAR_RST = 8'h00;
   localparam logic [2:0] CHAIN_RST = 3'h0;
   localparam logic [3:0] RATE_RST = 4'h0;
   localparam logic [7:0] UFC_RST = 8'h00;
   localparam logic [14:0] PRE_RST = 15'h0000;
   // Year range
   localparam logic [7:0] YEAR_MAX = 8'h63;
   // Timing: 32.768 kHz time base, one-second prescaler
   localparam int SLOW_HZ = 32768;
   localparam int PEND_LEAD_US = 488;
   localparam int RESUME_MS = 500;
   localparam int PEND_TICKS = 16;
   localparam logic [14:0] PRE_LAST = 15'h7FFF;
   localparam logic [14:0] PRE_PEND_AT = PRE_LAST - 15'(PEND_TICKS);
   // Scale before dividing; ticks per ms is not a whole number
   localparam logic [14:0] PRE_RESUME =
      PRE_LAST - 15'((SLOW_HZ * RESUME_MS) / 1000) + 15'h0001;
endpackage

// [design/rtcu_ctrl.sv]
// Calendar clock control: year count, divider chain, periodic rate,
// update gating, interrupt gates and presentation selects.
// Assumes a Wishbone classic master on clk_i and calendar logic alongside
// that consumes update pulses and the presentation selects.
//
// Functional notes
// - Year counts 0..99 and wraps; writes are not range-checked. Shown in binary or BCD per format select.
// - Pending flag rises 16 slow ticks before update, drops after it.
// - Chain code 11x halts; next 010 gives first update 500 ms later.
// - Counting needs chain code 010 and block enable both set.
// - Rate code selects period; 0 never fires; 3..F double from 122 us.
// - Rate codes 1 and 2 match the periods of codes 8 and 9.
// - Update inhibit suspends once-per-second updates until cleared.
// - Bit 6 gates periodic events onto the request.
// - Bit 5 gates alarm events onto the request.
// - Bit 4 gates update-ended events onto the request.
// - Bit 2 selects binary when one, BCD when zero; bit 3 reads zero.
// - Bit 1 selects 24-hour style when one, 12-hour with flag when zero.
// - Bit 0 enables the seasonal hour shift.
// - Selects translate only host accesses; storage stays binary.
// - Reading status clears the event flags and summary, but an event in the read cycle still sets its flag.
// - Summary bit 7 is any flag masked by its gate.
// - Each completed update sets update-ended; values then hold a second.
`timescale 1ns/1ns
module rtcu_ctrl import rtcu_pkg::*; #(
   parameter int CLK_HZ = 20000000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic block_en_i,
   input wire logic alarm_evt_i,
   input wire logic year_carry_i,
   output logic update_o,
   output logic periodic_o,
   output logic binary_mode_o,
   output logic hour_24_o,
   output logic seasonal_en_o,
   output logic request_o
);
   if (CLK_HZ < 2 * SLOW_HZ) begin : g_clk_check
      $error("CLK_HZ too low for the 32.768 kHz base");
   end

   function automatic logic [7:0] bcd2bin(input logic [7:0] v);
      bcd2bin = (8'(v[7:4]) * 8'h0A) + 8'(v[3:0]);
   endfunction

   function automatic logic [7:0] bin2bcd(input logic [7:0] v);
      logic [7:0] t;
      t = 8'(v / 8'h0A);
      bin2bcd = {t[3:0], 4'(v - 8'(t * 8'h0A))};
   endfunction

   // Bus decode; one-cycle ack, unmapped words read zero
   logic ack_q;
   logic [31:0] rdat_q;
   wire req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire lane0 = wb_sel_i[0];
   wire wr = req & wb_we_i & lane0;
   wire rd = req & ~wb_we_i;
   wire [3:0] idx = wb_adr_i[5:2];
   wire wr_year = wr & (idx == IDX_YEAR);
   wire wr_divrate = wr & (idx == IDX_DIVRATE);
   wire wr_updfmt = wr & (idx == IDX_UPDFMT);
   wire rd_status = rd & (idx == IDX_STATUS);

   // Slow tick from the fast clock by fractional accumulation
   localparam logic [31:0] ACC_MOD = 32'(CLK_HZ);
   localparam logic [31:0] ACC_STEP = 32'(SLOW_HZ);
   logic [31:0] acc_q;
   wire [31:0] acc_sum = acc_q + ACC_STEP;
   wire slow_tick = acc_sum >= ACC_MOD;
   wire [31:0] acc_d = slow_tick ? acc_sum - ACC_MOD : acc_sum;

   // Control registers
   logic [7:0] year_q;
   logic [2:0] chain_q;
   logic [3:0] rate_q;
   logic [7:0] ufc_q;
   logic pend_q;
   logic halted_q;
   logic [14:0] pre_q;
   logic [2:0] flags_q;

   wire fmt_bin = ufc_q[UFC_FMT_BIT];
   wire inhibit = ufc_q[UFC_INHIBIT_BIT];
   wire halt_code = chain_q[2:1] == CHAIN_HALT_TOP;
   wire run = (chain_q == CHAIN_RUN) & block_en_i;
   wire [7:0] wdat = wb_dat_i[7:0];
   wire [2:0] wchain = wdat[6:4];

   // Update at the prescaler wrap, unless inhibited
   wire at_last = slow_tick & run & (pre_q == PRE_LAST);
   wire upd = at_last & ~inhibit;
   wire pend_set = slow_tick & run & ~inhibit
      & (pre_q == PRE_PEND_AT);

   // Periodic event: period 2^(n-1) ticks for code n >= 3
   logic [3:0] eff_rate;
   always_comb begin
      case (rate_q)
         4'h1: eff_rate = 4'h8;
         4'h2: eff_rate = 4'h9;
         default: eff_rate = rate_q;
      endcase
   end
   wire [14:0] per_mask = 15'((16'h0001 << (eff_rate - 4'h1)) - 16'h0001);
   wire per_evt = slow_tick & run & (rate_q != RATE_RST)
      & ((pre_q & per_mask) == per_mask);

   // Sticky event flags; a new event wins over the read clear
   wire [2:0] evt = {per_evt, alarm_evt_i, upd};
   wire [2:0] gates = {ufc_q[UFC_PER_EN_BIT], ufc_q[UFC_ALM_EN_BIT],
      ufc_q[UFC_UPD_EN_BIT]};
   wire summary = |(flags_q & gates);
   wire [2:0] flags_d = evt | (rd_status ? 3'h0 : flags_q);

   // Year: binary inside, translated on access
   wire [7:0] year_wr = fmt_bin ? wdat : bcd2bin(wdat);
   wire [7:0] year_rd = fmt_bin ? year_q : bin2bcd(year_q);
   wire [7:0] year_inc = (year_q >= YEAR_MAX) ? YEAR_RST
      : year_q + 8'h01;

   logic [7:0] rd_byte;
   always_comb begin
      case (idx)
         IDX_YEAR: rd_byte = year_rd;
         IDX_DIVRATE: rd_byte = {pend_q, chain_q, rate_q};
         IDX_UPDFMT: rd_byte = ufc_q & ~(8'h01 << UFC_RSVD_BIT);
         IDX_STATUS: rd_byte = {summary, flags_q, 4'h0};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         acc_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         rdat_q <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         year_q <= YEAR_RST;
         chain_q <= CHAIN_RST;
         rate_q <= RATE_RST;
         ufc_q <= UFC_RST;
         flags_q <= 3'h0;
      end else begin
         if (wr_year)
            year_q <= year_wr;
         else if (upd & year_carry_i)
            year_q <= year_inc;
         if (wr_divrate) begin
            chain_q <= wchain;
            rate_q <= wdat[3:0];
         end
         if (wr_updfmt)
            ufc_q <= wdat & ~(8'h01 << UFC_RSVD_BIT);
         flags_q <= flags_d;
      end
   end

   // Prescaler and pending flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= PRE_RST;
         pend_q <= 1'b0;
         halted_q <= 1'b0;
      end else begin
         if (halt_code) begin
            pre_q <= PRE_RST;
            halted_q <= 1'b1;
         end else if (halted_q & (chain_q == CHAIN_RUN)) begin
            // Load a cycle after the write, so a halt always wins
            pre_q <= PRE_RESUME;
            halted_q <= 1'b0;
         end else if (slow_tick & run) begin
            pre_q <= pre_q + 15'h0001;
         end
         // Drops on the update, or if updating stops before it
         if (upd | ~run | inhibit)
            pend_q <= 1'b0;
         else if (pend_set)
            pend_q <= 1'b1;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign update_o = upd;
   assign periodic_o = per_evt;
   assign binary_mode_o = ufc_q[UFC_FMT_BIT];
   assign hour_24_o = ufc_q[UFC_H24_BIT];
   assign seasonal_en_o = ufc_q[UFC_DST_BIT];
   assign request_o = summary;

   // Checks
   sequence s_status_read;
      rd_status ##1 wb_ack_o;
   endsequence

   property p_pend_drops;
      @(posedge clk_i) disable iff (rst_i) upd |=> !pend_q;
   endproperty
   a_pend_drops: assert property (p_pend_drops)
      else $error("pending flag held after update");

   property p_pend_leads;
      @(posedge clk_i) disable iff (rst_i)
         upd && $past(run, 300) |-> pend_q;
   endproperty
   a_pend_leads: assert property (p_pend_leads)
      else $error("update without pending flag");

   property p_inhibit;
      @(posedge clk_i) disable iff (rst_i) inhibit |-> !update_o;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("update while inhibited");

   property p_run_only;
      @(posedge clk_i) disable iff (rst_i)
         (update_o || periodic_o) |-> (chain_q == CHAIN_RUN) && block_en_i;
   endproperty
   a_run_only: assert property (p_run_only)
      else $error("event while not counting");

   property p_halt;
      @(posedge clk_i) disable iff (rst_i)
         halt_code |=> pre_q == PRE_RST && halted_q;
   endproperty
   a_halt: assert property (p_halt)
      else $error("prescaler not cleared by halt");

   sequence s_resume_write;
      wr_divrate && halted_q && (wchain == CHAIN_RUN) ##1 chain_q == CHAIN_RUN;
   endsequence

   property p_resume;
      @(posedge clk_i) disable iff (rst_i)
         s_resume_write |=> pre_q == PRE_RESUME && !halted_q;
   endproperty
   a_resume: assert property (p_resume)
      else $error("prescaler not loaded on resume");

   property p_code0;
      @(posedge clk_i) disable iff (rst_i) rate_q == 4'h0 |-> !periodic_o;
   endproperty
   a_code0: assert property (p_code0)
      else $error("periodic event with code zero");

   property p_uend;
      @(posedge clk_i) disable iff (rst_i)
         update_o |=> flags_q[0] ##1 !update_o [*8];
   endproperty
   a_uend: assert property (p_uend)
      else $error("update-ended flag missing or updates too close");

   property p_summary;
      @(posedge clk_i) disable iff (rst_i)
         request_o == ((flags_q[2] && ufc_q[UFC_PER_EN_BIT])
            || (flags_q[1] && ufc_q[UFC_ALM_EN_BIT])
            || (flags_q[0] && ufc_q[UFC_UPD_EN_BIT]));
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary does not match gated flags");

   property p_read_clears;
      @(posedge clk_i) disable iff (rst_i)
         rd_status && !per_evt && !alarm_evt_i && !upd |=> flags_q == 3'h0;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status read did not clear flags");

   property p_status_data;
      @(posedge clk_i) disable iff (rst_i)
         s_status_read |-> wb_dat_o[ST_REQ_BIT] == $past(summary);
   endproperty
   a_status_data: assert property (p_status_data)
      else $error("status read returned wrong summary");

   property p_year_range;
      @(posedge clk_i) disable iff (rst_i)
         $past(year_q <= YEAR_MAX) && !$past(wr_year) |-> year_q <= YEAR_MAX;
   endproperty
   a_year_range: assert property (p_year_range)
      else $error("year left range by counting");

   property p_year_wrap;
      @(posedge clk_i) disable iff (rst_i)
         upd && year_carry_i && !wr_year && year_q == YEAR_MAX
            |=> year_q == 8'h00;
   endproperty
   a_year_wrap: assert property (p_year_wrap)
      else $error("year did not wrap to zero");

   property p_pend_rise;
      @(posedge clk_i) disable iff (rst_i)
         $rose(pend_q) |-> $past(pend_set);
   endproperty
   a_pend_rise: assert property (p_pend_rise)
      else $error("pending flag rose away from its lead point");
endmodule

// [verif/rtc_update_rate_format_control_test.sv]
// Self-checking bench for the calendar clock control block.
// Assumes CLK_HZ lowered to 65536, so one slow tick is two clocks.
`timescale 1ns/1ns
module rtc_update_rate_format_control_test;
   import rtcu_pkg::*;
   localparam int FHZ = 65536;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic blk_en = 0, alm = 0, ycar = 0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000, rdat, dat_o;
   logic ack_o, upd_o, per_o, bin_o, h24_o, sea_o, req_o;
   int n_mismatch = 0, tests_run = 0, cyc_n = 0;
   int t0, v, w, n, m;

   rtcu_ctrl #(.CLK_HZ(FHZ)) rtcu_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
      .block_en_i(blk_en), .alarm_evt_i(alm), .year_carry_i(ycar),
      .update_o(upd_o), .periodic_o(per_o), .binary_mode_o(bin_o),
      .hour_24_o(h24_o), .seasonal_en_o(sea_o), .request_o(req_o));

   always #25 clk_i = ~clk_i;

   // Hang guard: the planned run is about 80k cycles
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 95000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Request held until ack is sampled high, then released
   task automatic bus(logic wr_en, logic [3:0] idx, logic [7:0] d,
                      logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr_en;
      adr <= {idx, 2'h0};
      sel <= s;
      wdat <= {24'h000000, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(logic [3:0] idx, logic [7:0] d);
      bus(1'b1, idx, d, 4'hF);
   endtask

   task automatic rd(logic [3:0] idx, logic [7:0] exp, string nm);
      bus(1'b0, idx, 8'h00, 4'hF);
      check(nm, rdat, {24'h000000, exp});
   endtask

   task automatic wait_per();
      do @(posedge clk_i); while (per_o !== 1'b1);
   endtask

   // Counts periodic pulses into n and update pulses into m
   task automatic cnt(int len);
      n = 0;
      m = 0;
      repeat (len) begin
         @(posedge clk_i);
         n += (per_o === 1'b1);
         m += (upd_o === 1'b1);
      end
   endtask

   function automatic logic [7:0] bcd(int x);
      return 8'((x / 10) * 16 + x % 10);
   endfunction

   // Codes 1 and 2 alias 8 and 9; two clocks per slow tick
   function automatic int per_clk(int c);
      return 2 * ((c < 3) ? (1 << (c + 6)) : (1 << (c - 1)));
   endfunction

   initial begin
      void'($urandom(85978));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_YEAR, 8'h00, "year rst");
      rd(IDX_DIVRATE, 8'h00, "divrate rst");
      rd(IDX_UPDFMT, 8'h00, "updfmt rst");
      rd(IDX_STATUS, 8'h00, "status rst");
      rd(4'hF, 8'h00, "unmapped");
      wr(IDX_UPDFMT, 8'hFF);
      rd(IDX_UPDFMT, 8'hF7, "updfmt rsvd");
      check("selects", {bin_o, h24_o, sea_o}, 32'h7);
      wr(IDX_UPDFMT, 8'h04);
      for (int i = 0; i < 4; i++) begin
         v = $urandom % 100;
         w = (i == 0) ? 99 : $urandom % 100;
         wr(IDX_YEAR, 8'(v));
         rd(IDX_YEAR, 8'(v), "year bin");
         wr(IDX_UPDFMT, 8'h00);
         rd(IDX_YEAR, bcd(v), "year bcd");
         wr(IDX_YEAR, bcd(w));
         wr(IDX_UPDFMT, 8'h04);
         rd(IDX_YEAR, 8'(w), "year from bcd");
      end
      bus(1'b1, IDX_YEAR, 8'h11, 4'h0);
      rd(IDX_YEAR, 8'(w), "sel0 dropped");
      for (int g = 0; g < 2; g++) begin
         wr(IDX_UPDFMT, g ? 8'h24 : 8'h04);
         @(posedge clk_i);
         alm <= 1'b1;
         @(posedge clk_i);
         alm <= 1'b0;
         @(posedge clk_i);
         check("alarm req", req_o, g);
         rd(IDX_STATUS, g ? 8'hA0 : 8'h20, "alarm flag");
         rd(IDX_STATUS, 8'h00, "status cleared");
      end
      wr(IDX_DIVRATE, 8'h20);
      blk_en <= 1'b1;
      wr(IDX_UPDFMT, 8'h44);
      for (int c = 1; c < 12; c++) begin
         wr(IDX_DIVRATE, 8'h20 | 8'(c));
         wait_per();
         t0 = cyc_n;
         wait_per();
         check("period", cyc_n - t0, per_clk(c));
      end
      @(posedge clk_i);
      check("per req", req_o, 1);
      wr(IDX_UPDFMT, 8'h04);
      rd(IDX_STATUS, 8'h40, "per flag masked");
      wait_per();
      @(posedge clk_i);
      check("per gated", req_o, 0);
      rd(IDX_STATUS, 8'h40, "per flag gated");
      wr(IDX_DIVRATE, 8'h20);
      cnt(600);
      check("rate0", n, 0);
      blk_en <= 1'b0;
      wr(IDX_DIVRATE, 8'h23);
      cnt(600);
      check("disabled", n, 0);
      wr(IDX_DIVRATE, 8'h70);
      blk_en <= 1'b1;
      wr(IDX_UPDFMT, 8'h84);
      wr(IDX_DIVRATE, 8'h20);
      cnt(33200);
      check("inhibit upd", m, 0);
      rd(IDX_DIVRATE, 8'h20, "pend inhibited");
      wr(IDX_UPDFMT, 8'h14);
      ycar <= 1'b1;
      wr(IDX_YEAR, 8'h63);
      wr(IDX_DIVRATE, 8'h60);
      wr(IDX_DIVRATE, 8'h20);
      t0 = cyc_n;
      repeat (32740) @(posedge clk_i);
      rd(IDX_DIVRATE, 8'hA0, "pending");
      do @(posedge clk_i); while (upd_o !== 1'b1);
      check("first upd", (cyc_n - t0) inside {[32760:32772]}, 1);
      @(posedge clk_i);
      check("upd req", req_o, 1);
      rd(IDX_DIVRATE, 8'h20, "pend dropped");
      rd(IDX_STATUS, 8'h90, "upd ended");
      rd(IDX_YEAR, 8'h00, "year wrap");
      wr(IDX_YEAR, 8'h2A);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_YEAR, 8'h00, "year mid rst");
      rd(IDX_UPDFMT, 8'h00, "updfmt mid rst");
      rd(IDX_DIVRATE, 8'h00, "divrate mid rst");
      check("selects rst", {bin_o, h24_o, sea_o}, 32'h0);
      final_report();
   end
endmodule
